// >>> rtl/sflm_pkg.sv
package sflm_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int ADDR_BITS = 16;
   localparam int CTRL_BITS = 8;
   localparam int BYTE_BITS = 8;
   localparam int BIT_CNT_W = 4;
   localparam logic [3:0] ADDR_LAST_BIT = 4'hF;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

   // Control byte field positions.
   localparam int CTRL_BSB_HI = 7;
   localparam int CTRL_BSB_LO = 3;
   localparam int CTRL_DIR_POS = 2;
   localparam int CTRL_LEN_HI = 1;
   localparam int CTRL_LEN_LO = 0;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   localparam logic [1:0] LEN_VAR = 2'h0;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_FOUR = 2'h3;
   localparam logic DIR_READ = 1'b0;
   localparam logic DIR_WRITE = 1'b1;

   typedef enum logic [1:0] {
      AREA_COMMON = 2'b00,
      AREA_SOCK_REG = 2'b01,
      AREA_TX_BUF = 2'b10,
      AREA_RX_BUF = 2'b11
   } sflm_area_e;

   typedef enum logic [1:0] {
      ST_ADDR = 2'b00,
      ST_CTRL = 2'b01,
      ST_DATA = 2'b10
   } sflm_state_e;

   // Access request toward the internal memory side.
   typedef struct packed {
      logic [15:0] addr;
      logic [2:0] socket;
      sflm_area_e area;
      logic write;
      logic [7:0] wdata;
   } sflm_req_s;

   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : sflm_pkg

// >>> rtl/sflm_sync.sv
module sflm_sync
   import sflm_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // Only the second stage is read outside this module.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // sflm_sync

// >>> rtl/sflm_slave.sv
// Operation
// - Control length bits choose data length
// - Every byte shifted MSB first
// - Variable mode lasts while select low
// - Write: direction 1, data on MOSI
// - Read: direction 0, MISO on falling
// - Extra bytes access successive addresses
// - Address, control byte, then data
// - Block bits give socket and area
module sflm_slave
   import sflm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic chip_select_low,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   output sflm_req_s req,
   output logic req_valid,
   output logic rd_strobe,
   input wire logic [7:0] rd_data
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic sclk_s;
   logic cs_s;
   logic mosi_s;
   logic sclk_d;
   logic cs_d;
   logic rise;
   logic fall;
   logic cs_rise;

   sflm_sync #(.WIDTH(3)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({sclk, chip_select_low, mosi}),
      .sync_out(pins_sync)
   );

   assign sclk_s = pins_sync[2];
   assign cs_s = pins_sync[1];
   assign mosi_s = pins_sync[0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_d <= cs_s;
      end
   end

   // Clock edges count only while selected, so the clock line may wander
   // between frames without shifting anything.
   assign rise = sclk_s & ~sclk_d & ~cs_s;
   assign fall = ~sclk_s & sclk_d & ~cs_s;
   // The synchroniser clears to zero, so one deselect edge is seen just
   // after reset while the pin idles high. It is harmless: it only returns
   // the sequencer to the address phase that reset has already chosen.
   assign cs_rise = cs_s & ~cs_d;

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------
   sflm_state_e state;
   logic [3:0] bit_cnt;
   logic [15:0] shreg;
   logic [15:0] addr;
   logic [7:0] ctrl;
   logic [2:0] bytes_left;
   logic [7:0] rd_shift;
   logic last_bit;
   logic [7:0] next_byte;

   // Code 00 maps to zero bytes: the count never runs out, so only a
   // rising select ends an open-ended frame.
   function automatic logic [2:0] len_bytes(input logic [1:0] code);
      case (code)
         LEN_ONE: len_bytes = 3'h1;
         LEN_TWO: len_bytes = 3'h2;
         LEN_FOUR: len_bytes = 3'h4;
         default: len_bytes = 3'h0;
      endcase
   endfunction

   assign last_bit = (state == ST_ADDR) ? (bit_cnt == ADDR_LAST_BIT)
                                        : (bit_cnt == BYTE_LAST_BIT);
   assign next_byte = {shreg[6:0], mosi_s};

   // A fixed frame that is cut short leaves the sequencer mid-frame with
   // select tied low; nothing but a reset brings it back into step.
   // address control data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_ADDR;
         bit_cnt <= '0;
         shreg <= ADDR_RESET;
         addr <= ADDR_RESET;
         ctrl <= BYTE_RESET;
         bytes_left <= '0;
      end else if (cs_rise) begin
         state <= ST_ADDR;
         bit_cnt <= '0;
      end else if (rise) begin
         shreg <= {shreg[14:0], mosi_s};
         bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
         if (last_bit) begin
            case (state)
               ST_ADDR: begin
                  addr <= {shreg[14:0], mosi_s};
                  state <= ST_CTRL;
               end
               ST_CTRL: begin
                  ctrl <= next_byte;
                  bytes_left <= len_bytes(next_byte[CTRL_LEN_HI:CTRL_LEN_LO]);
                  state <= ST_DATA;
               end
               ST_DATA: begin
                  addr <= addr + 16'h0001;
                  if (ctrl[CTRL_LEN_HI:CTRL_LEN_LO] != LEN_VAR) begin
                     bytes_left <= bytes_left - 3'h1;
                     if (bytes_left == 3'h1) begin
                        state <= ST_ADDR;
                     end
                  end
               end
               default: state <= ST_ADDR;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Internal access requests
   // ----------------------------------------------------------------
   logic data_done;
   logic rd_load;
   // A fixed-length read ends with one fetch past its last byte; the memory
   // side must accept such a spare read without side effects.
   assign data_done = rise & last_bit & (state == ST_DATA);
   // A read fetches on entry to the data phase and after each byte.
   assign rd_load = rise & last_bit & ((state == ST_CTRL)
                  ? (next_byte[CTRL_DIR_POS] == DIR_READ)
                  : ((state == ST_DATA) & (ctrl[CTRL_DIR_POS] == DIR_READ)));

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req <= '0;
         req_valid <= 1'b0;
         rd_strobe <= 1'b0;
      end else begin
         req_valid <= 1'b0;
         rd_strobe <= 1'b0;
         if (data_done && ctrl[CTRL_DIR_POS] == DIR_WRITE) begin
            req.addr <= addr;
            req.write <= 1'b1;
            req.wdata <= next_byte;
            req.socket <= ctrl[CTRL_BSB_HI:CTRL_BSB_HI-2];
            req.area <= sflm_area_e'(ctrl[CTRL_BSB_LO+1:CTRL_BSB_LO]);
            req_valid <= 1'b1;
         end else if (rd_load) begin
            req.addr <= (state == ST_CTRL) ? addr : addr + 16'h0001;
            req.write <= 1'b0;
            req.wdata <= BYTE_RESET;
            req.socket <= (state == ST_CTRL)
                          ? next_byte[CTRL_BSB_HI:CTRL_BSB_HI-2]
                          : ctrl[CTRL_BSB_HI:CTRL_BSB_HI-2];
            req.area <= sflm_area_e'((state == ST_CTRL)
                          ? next_byte[CTRL_BSB_LO+1:CTRL_BSB_LO]
                          : ctrl[CTRL_BSB_LO+1:CTRL_BSB_LO]);
            rd_strobe <= 1'b1;
            req_valid <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data return
   // ----------------------------------------------------------------
   // Data are fetched one cycle after the strobe, long before the
   // first falling edge of the byte at any legal clock rate.
   logic rd_pending;
   logic rd_active;
   assign rd_active = (state == ST_DATA) && (ctrl[CTRL_DIR_POS] == DIR_READ);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_pending <= 1'b0;
         rd_shift <= BYTE_RESET;
         miso <= 1'b0;
         miso_oe_n <= 1'b1;
      end else begin
         rd_pending <= rd_strobe;
         miso_oe_n <= ~(rd_active & ~cs_s);
         if (rd_pending) begin
            rd_shift <= rd_data;
         end else if (fall && rd_active) begin
            miso <= rd_shift[7];
            rd_shift <= {rd_shift[6:0], 1'b0};
         end
      end
   end

endmodule // sflm_slave

// >>> dv/sflm_slave_chk.sv
module sflm_slave_chk
   import sflm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic chip_select_low,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n,
   input wire sflm_req_s req,
   input wire logic req_valid,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_data
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   reset_quiet_a: assert property (disable iff (1'b0) rst |=>
      !req_valid && !rd_strobe && miso_oe_n) else $error("active in reset");
   valid_pulse_a: assert property (req_valid |=> !req_valid)
      else $error("request longer than one cycle");
   strobe_pulse_a: assert property (rd_strobe |=> !rd_strobe)
      else $error("fetch longer than one cycle");
   read_fetch_a: assert property (rd_strobe |->
      req_valid && req.write == DIR_READ) else $error("fetch not a read");
   idle_quiet_a: assert property (chip_select_low [*6] |->
      !req_valid && !rd_strobe) else $error("request while deselected");
   idle_float_a: assert property (chip_select_low [*6] |-> miso_oe_n)
      else $error("output driven while deselected");
   req_hold_a: assert property (!req_valid |-> $stable(req))
      else $error("request moved without valid");
   miso_edge_a: assert property (!miso_oe_n && $changed(miso) |-> !sclk)
      else $error("output moved with clock high");
endmodule // sflm_slave_chk

bind sflm_slave sflm_slave_chk u_chk (.clk_sys, .rst, .sclk,
   .chip_select_low, .mosi, .miso, .miso_oe_n, .req, .req_valid,
   .rd_strobe, .rd_data);

// >>> dv/sflm_host.sv
module sflm_host (
   output logic sclk,
   output logic chip_select_low,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] wb [4];
   logic [7:0] rb [4];
   // A released output reads as z, so a missing drive shows as a mismatch.
   wire logic miso_pin = miso_oe_n ? 1'bz : miso;
   initial begin
      sclk = 1'b0;
      chip_select_low = 1'b1;
      mosi = 1'b0;
   end
   task automatic bit1(input logic b, output logic r);
      mosi = b;
      #80 sclk = 1'b1;
      r = miso_pin;
      #80 sclk = 1'b0;
   endtask
   task automatic frame(input logic [23:0] h, input int n, input bit fix);
      logic r;
      chip_select_low = 1'b0;
      #80;
      for (int i = 23; i >= 0; i--) bit1(h[i], r);
      for (int i = 0; i < n * 8; i++) begin
         bit1(wb[i / 8][7 - i % 8], r);
         rb[i / 8][7 - i % 8] = r;
      end
      chip_select_low = !fix;
      mosi = !mosi;
      #400;
   endtask
endmodule // sflm_host

// >>> dv/spi_frame_length_modes_tb.sv
module spi_frame_length_modes_tb
   import sflm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rd_data = 8'h00;
   logic sclk, chip_select_low, mosi, miso, miso_oe_n, req_valid, rd_strobe;
   sflm_req_s req;
   sflm_req_s got [$];
   int errors = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h06B2C845;
   always #5 clk_sys = !clk_sys;
   sflm_slave u_dut (.clk_sys, .rst, .sclk, .chip_select_low, .mosi, .miso,
      .miso_oe_n, .req, .req_valid, .rd_strobe, .rd_data);
   sflm_host u_host (.sclk, .chip_select_low, .mosi, .miso, .miso_oe_n);
   function automatic logic [7:0] rdv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // The memory side answers a fetch at the falling edge inside the strobe cycle, a cycle and a half before the design takes the data.
   always @(negedge clk_sys) begin
      if (rd_strobe === 1'b1) rd_data <= rdv(req.addr);
   end
   // Requests are taken mid-cycle, where the registered pulse has settled.
   always @(negedge clk_sys) begin
      if (req_valid === 1'b1) got.push_back(req);
   end
   task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400_000;
      errors++;
      final_report();
   end
   initial begin
      logic [15:0] a;
      logic [7:0] c;
      sflm_req_s e;
      int n;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      // Host steps are whole system periods, so pins move at falling edges.
      #330;
      for (int k = 0; k < 16; k++) begin
         a = 16'(rnd());
         c = {5'(rnd()), k[0], k[2:1]};
         n = c[1:0] == LEN_FOUR ? 4 : int'(c[1:0]);
         if (c[1:0] == LEN_VAR) n = 1 + int'(rnd() % 4);
         foreach (u_host.wb[i]) u_host.wb[i] = 8'(rnd());
         got.delete();
         u_host.frame({a, c}, n, c[1:0] != LEN_VAR);
         for (int i = 0; i < n; i++) begin
            e = '{a + 16'(i), c[7:5], sflm_area_e'(c[4:3]), c[2],
               u_host.wb[i]};
            chk(got[i][34:8], e[34:8]);
            if (c[2]) chk(got[i].wdata, e.wdata);
            else chk(u_host.rb[i], rdv(e.addr));
         end
         if (c[2]) chk(got.size(), n);
      end
      final_report();
   end
endmodule // spi_frame_length_modes_tb
